/* File: bench/plt_link_if_checker.sv */
// Port checker for the PHY-side link interface
`timescale 1ns/1ns
module plt_link_if_checker (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [1:0] interface_control_lines,
   input wire logic [7:0] data_lines,
   input wire logic drive_enable,
   input wire logic request_clear
);
   // ====
   // Status run and speed-seen trackers
   wire logic [1:0] c = interface_control_lines;
   logic [3:0] run;
   logic [3:0] next_run;
   logic seen;
   logic next_seen;
   always_comb begin
      next_run = (c == 2'h1) ? run + 4'h1 : 4'h0;
      next_seen = (c == 2'h2) && (seen || data_lines != 8'hFF);
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         run <= 4'h0;
         seen <= 1'b0;
      end else begin
         run <= next_run;
         seen <= next_seen;
      end
   end
   // ====
   // Properties
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   AST_STAT_START: assert property ((c != 2'h1 ##1 c == 2'h1) |-> $past(c) == 2'h0)
      else $error("status not from idle");
   AST_STAT_LEN: assert property (($past(c) == 2'h1 && c inside {2'h0, 2'h3})
      |-> run inside {4'h2, 4'h8}) else $error("status length");
   AST_STAT_MAX: assert property (run == 4'h8 |-> c != 2'h1)
      else $error("status too long");
   AST_GNT: assert property (c == 2'h3 |=> c == 2'h0 ##1 !drive_enable)
      else $error("grant handover");
   AST_GNT_FROM: assert property (c == 2'h3 |-> $past(c) inside {2'h0, 2'h1})
      else $error("grant source");
   AST_RX_ON: assert property ((c != 2'h2 ##1 c == 2'h2)
      |-> data_lines == 8'hFF && request_clear) else $error("rx start");
   AST_RX_END: assert property ((c == 2'h2 ##1 c != 2'h2) |-> c == 2'h0)
      else $error("rx end");
   AST_SPD: assert property ((c == 2'h2 && !seen && data_lines != 8'hFF)
      |-> data_lines inside {8'h00, 8'h40, 8'h50}) else $error("speed code");
   cover property (c == 2'h1 ##1 c == 2'h2);
   cover property (run == 4'h8 && c == 2'h0);
   cover property (c == 2'h1 ##1 c == 2'h3);
endmodule // plt_link_if_checker

bind plt_link_if plt_link_if_checker u_chk (
   .clk_sys(clk_sys),
   .reset(reset),
   .interface_control_lines(interface_control_lines),
   .data_lines(data_lines),
   .drive_enable(drive_enable),
   .request_clear(request_clear)
);

/* File: bench/plt_link_if_tb_top.sv */
// Self-checking bench for the PHY-side link interface
`timescale 1ns/1ns
module plt_link_if_tb_top;
   // ====
   // Signals and instances
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [3:0] ev = 4'h0;
   logic reg_load = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_data = 8'h00;
   logic rx_prefix = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_end = 1'b0;
   logic arb_won = 1'b0;
   logic [1:0] rx_speed = 2'h0;
   logic [7:0] rx_symbol = 8'h00;
   logic link_release;
   logic [1:0] ctl;
   logic [7:0] dl;
   logic [7:0] spd;
   logic de;
   logic rclr;
   int num_errors = 0;
   int checks_done = 0;
   plt_link_if dut (.clk_sys(clk_sys), .reset(reset), .arb_gap_event(ev[0]),
      .sub_gap_event(ev[1]), .bus_reset_event(ev[2]), .phy_int_event(ev[3]),
      .reg_load(reg_load), .reg_addr(reg_addr), .reg_data(reg_data),
      .rx_prefix(rx_prefix), .rx_valid(rx_valid), .rx_speed(rx_speed),
      .rx_symbol(rx_symbol), .rx_end(rx_end), .arb_won(arb_won),
      .link_release(link_release), .interface_control_lines(ctl), .data_lines(dl),
      .drive_enable(de), .request_clear(rclr));
   plt_link_model u_link (.clk_sys(clk_sys), .interface_control_lines(ctl),
      .data_lines(dl), .drive_enable(de), .link_release(link_release),
      .speed_seen(spd));
   initial begin
      forever #2 clk_sys = ~clk_sys;
   end
   // ====
   // Helpers
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   task automatic wctl(input logic [1:0] code);
      int i;
      for (i = 0; i < 40 && ctl !== code; i++) cyc(1);
      chk(ctl, code);
   endtask
   task automatic stat(input logic [15:0] w, input int n);
      int k;
      for (k = 0; k < n; k++) begin
         chk(ctl, 2'h1);
         chk(dl[1:0], w[2*k +: 2]);
         cyc(1);
      end
      chk(ctl, 2'h0);
   endtask
   task automatic pre(input logic [1:0] s);
      rx_speed = s;
      rx_prefix = 1'b1;
      cyc(1);
      rx_prefix = 1'b0;
   endtask
   // ====
   // Scenarios
   task automatic t_flags();
      int i;
      for (i = 0; i < 4; i++) begin
         ev[i] = 1'b1;
         cyc(1);
         ev = 4'h0;
         wctl(2'h1);
         stat(16'h1 << i, 2);
         cyc(2);
      end
   endtask
   task automatic t_rx(input logic [1:0] s, input logic [7:0] code, input logic [7:0] lane);
      pre(s);
      wctl(2'h2);
      chk(dl, 8'hFF);
      chk(rclr, 1'b1);
      rx_symbol = 8'hA5;
      rx_valid = 1'b1;
      cyc(1);
      chk(dl, code);
      chk(rclr, 1'b0);
      cyc(1);
      chk(dl, lane);
      chk(spd, code);
      rx_valid = 1'b0;
      rx_end = 1'b1;
      cyc(1);
      rx_end = 1'b0;
      wctl(2'h0);
   endtask
   task automatic t_null();
      int i;
      pre(2'h2);
      rx_end = 1'b1;
      wctl(2'h2);
      for (i = 0; i < 8 && ctl === 2'h2; i++) begin
         chk(dl, 8'hFF);
         cyc(1);
      end
      rx_end = 1'b0;
      chk(ctl, 2'h0);
   endtask
   task automatic t_retry();
      int i;
      reg_addr = 4'hA;
      reg_data = 8'h5C;
      reg_load = 1'b1;
      cyc(1);
      reg_load = 1'b0;
      wctl(2'h1);
      pre(2'h0);
      for (i = 0; i < 4 && ctl === 2'h1; i++) cyc(1);
      chk(ctl, 2'h2);
      rx_end = 1'b1;
      wctl(2'h0);
      rx_end = 1'b0;
      wctl(2'h1);
      stat(16'h5CA0, 8);
   endtask
   task automatic t_grant(input bit st);
      int i;
      if (st) begin
         ev[1] = 1'b1;
         cyc(1);
         ev = 4'h0;
         wctl(2'h1);
      end
      arb_won = 1'b1;
      wctl(2'h3);
      arb_won = 1'b0;
      cyc(1);
      chk(ctl, 2'h0);
      cyc(1);
      chk(de, 1'b0);
      for (i = 0; i < 20 && de !== 1'b1; i++) cyc(1);
      chk(de, 1'b1);
      chk(ctl, 2'h0);
   endtask
   // ====
   // Sequence, watchdog and verdict
   task automatic results();
      if (num_errors == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      cyc(8);
      reset = 1'b0;
      cyc(2);
      t_flags();
      t_rx(2'h2, 8'h50, 8'hA5);
      t_rx(2'h1, 8'h40, 8'h05);
      t_rx(2'h0, 8'h00, 8'h01);
      t_null();
      t_retry();
      t_grant(1'b0);
      t_grant(1'b1);
      results();
   end
   initial begin
      // Whole run is well under two hundred cycles
      #20000;
      num_errors++;
      results();
   end
endmodule // plt_link_if_tb_top

/* File: bench/plt_link_model.sv */
// Link controller model on the far side of the interface
`timescale 1ns/1ns
module plt_link_model #(
   parameter int HOLD_CYC = 3
) (
   input wire logic clk_sys,
   input wire logic [1:0] interface_control_lines,
   input wire logic [7:0] data_lines,
   input wire logic drive_enable,
   output logic link_release,
   output logic [7:0] speed_seen
);
   // ====
   // Release after a short hold, decode speed
   int cnt = 0;
   logic dec = 1'b0;
   initial link_release = 1'b0;
   initial speed_seen = 8'hFF;
   always @(negedge clk_sys) begin
      cnt <= drive_enable ? 0 : cnt + 1;
      // One-cycle release pulse after a short hold
      link_release <= !drive_enable && cnt == HOLD_CYC;
      dec <= (interface_control_lines == 2'h2) && (dec || data_lines != 8'hFF);
      // Speed kept out of any packet check
      if (interface_control_lines == 2'h2 && !dec && data_lines != 8'hFF)
         speed_seen <= data_lines;
   end
endmodule // plt_link_model

/* File: inc/plt_consts.svh */
// Constants for the PHY-side link interface block
`ifndef PLT_CONSTS_SVH
`define PLT_CONSTS_SVH
// ==========================================
// Control line codes
`define PLT_CTL_IDLE 2'h0
`define PLT_CTL_STATUS 2'h1
`define PLT_CTL_RECEIVE 2'h2
`define PLT_CTL_GRANT 2'h3
// ==========================================
// Data line codes
`define PLT_DATA_ON 8'hFF
`define PLT_SPD_S100 8'h00
`define PLT_SPD_S200 8'h40
`define PLT_SPD_S400 8'h50
// ==========================================
// Speed selects
`define PLT_SPEED_S100 2'h0
`define PLT_SPEED_S200 2'h1
`define PLT_SPEED_S400 2'h2
// ==========================================
// Status frame layout and last cycle index of short and long status
`define PLT_FLAG_ARB_GAP 0
`define PLT_FLAG_SUB_GAP 1
`define PLT_FLAG_BUS_RESET 2
`define PLT_FLAG_INTERRUPT 3
`define PLT_STAT_SHORT_CYC 3'h1
`define PLT_STAT_LONG_CYC 3'h7
`endif

/* File: inc/plt_pkg.sv */
// Types for the PHY-side link interface block
package plt_pkg;
   typedef enum logic [2:0] {
      PLT_IDLE = 3'b000,
      PLT_STATUS = 3'b001,
      PLT_RX_ON = 3'b010,
      PLT_RX_SPEED = 3'b011,
      PLT_RX_DATA = 3'b100,
      PLT_GRANT = 3'b101,
      PLT_GRANT_IDLE = 3'b110,
      PLT_RELEASED = 3'b111
   } plt_state_e;
endpackage

/* File: logic/plt_link_if.sv */
// PHY end of the PHY-to-link parallel interface
`timescale 1ns/1ns
`include "plt_consts.svh"
// Notes on behaviour
// - Status bit 0 reports bus idle for arbitration reset gap.
// - Status bit 1 reports bus idle for subaction gap.
// - Status bit 2 reports entry into bus reset.
// - Status bit 3 reports a PHY interrupt event.
// - Long status: bits 4-7 register address, bits 8-15 register contents.
// - Status code on control lines, two status bits per clock on lowest lines.
// - Status lasts 2 cycles for flags, 8 cycles with register contents.
// - Status ends with idle or grant, or is cut short by receive.
// - At least one idle cycle between consecutive status transfers.
// - Grant may follow a completed status transfer with no idle.
// - Data-prefix starts receive with all ones on data lines.
// - Speed code stands exactly one cycle directly before packet data.
// - Receive held until last symbol, then at least one idle.
// - Speed code is never part of CRC or data protection.
// - Null packet: data-on cycles then idle, no speed code or data.
// - Every reception sends at least one data-on cycle first.
// - Own self-ID packet forwarded like any received packet.
// - Speed codes S100 00h, S200 40h, S400 50h, data-on FFh.
// - Reception may interrupt a status transfer directly.
// - Grant one clock, then idle one clock, then hand over.
// - Status code is 01b, started only from an idle interface.
// - Receive code is 10b; asserting it clears pending fair/priority requests.
// - Flags delivered when sent; register only after all eight bits.
module plt_link_if
   import plt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic arb_gap_event,
   input wire logic sub_gap_event,
   input wire logic bus_reset_event,
   input wire logic phy_int_event,
   input wire logic reg_load,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_data,
   input wire logic rx_prefix,
   input wire logic rx_valid,
   input wire logic [1:0] rx_speed,
   input wire logic [7:0] rx_symbol,
   input wire logic rx_end,
   input wire logic arb_won,
   input wire logic link_release,
   output logic [1:0] interface_control_lines,
   output logic [7:0] data_lines,
   output logic drive_enable,
   output logic request_clear
);
   plt_state_e state, next_state;
   logic [2:0] cyc, next_cyc;
   logic long_xfer, next_long_xfer;
   logic [15:0] frame, next_frame;
   logic idle_seen, next_idle_seen;
   logic [1:0] speed, next_speed;
   logic [1:0] next_ctl;
   logic [7:0] next_data;
   logic next_drive_enable;
   logic next_request_clear;
   logic flags_sent;
   logic reg_sent;
   logic [3:0] flags_pend;
   logic reg_pend;
   logic [11:0] reg_word;
   logic [7:0] lanes;
   logic [7:0] speed_code;
   logic [3:0] flag_set;
   // ==========================================
   // Event collection
   assign flag_set = {phy_int_event, bus_reset_event, sub_gap_event, arb_gap_event};
   plt_status_queue u_queue (
      .clk_sys(clk_sys),
      .reset(reset),
      .flag_set(flag_set),
      .reg_load(reg_load),
      .reg_addr(reg_addr),
      .reg_data(reg_data),
      .flags_sent(flags_sent),
      .reg_sent(reg_sent),
      .flags_pend(flags_pend),
      .reg_pend(reg_pend),
      .reg_word(reg_word)
   );
   // Speed code never enters the data path the CRC sees
   plt_rx_packer u_packer (
      .speed(speed),
      .symbol(rx_symbol),
      .lanes(lanes),
      .speed_code(speed_code)
   );
   // ==========================================
   // Interface sequencer
   always_comb begin
      next_state = state;
      next_cyc = cyc;
      next_long_xfer = long_xfer;
      next_frame = frame;
      next_idle_seen = 1'b0;
      next_speed = speed;
      next_ctl = `PLT_CTL_IDLE;
      next_data = 8'h00;
      next_drive_enable = 1'b1;
      next_request_clear = 1'b0;
      flags_sent = 1'b0;
      reg_sent = 1'b0;
      case (state)
         PLT_IDLE: begin
            next_idle_seen = 1'b1;
            if (rx_prefix) begin
               next_state = PLT_RX_ON;
               next_speed = rx_speed;
               next_ctl = `PLT_CTL_RECEIVE;
               next_data = `PLT_DATA_ON;
               next_request_clear = 1'b1;
            end else if (arb_won) begin
               next_state = PLT_GRANT_IDLE;
               next_ctl = `PLT_CTL_GRANT;
            end else if (idle_seen && (flags_pend != 4'h0 || reg_pend)) begin
               next_state = PLT_STATUS;
               next_cyc = 3'h0;
               next_long_xfer = reg_pend;
               next_frame = {reg_word[11:4], reg_word[3:0], flags_pend};
               next_ctl = `PLT_CTL_STATUS;
               next_data = {6'h00, flags_pend[1], flags_pend[0]};
               flags_sent = 1'b1;
            end
         end
         PLT_STATUS: begin
            if (rx_prefix) begin
               next_state = PLT_RX_ON;
               next_speed = rx_speed;
               next_ctl = `PLT_CTL_RECEIVE;
               next_data = `PLT_DATA_ON;
               next_request_clear = 1'b1;
            end else if (cyc == (long_xfer ? `PLT_STAT_LONG_CYC : `PLT_STAT_SHORT_CYC)) begin
               reg_sent = long_xfer;
               if (arb_won) begin
                  next_state = PLT_GRANT_IDLE;
                  next_ctl = `PLT_CTL_GRANT;
               end else begin
                  next_state = PLT_IDLE;
               end
            end else begin
               next_cyc = cyc + 3'h1;
               next_ctl = `PLT_CTL_STATUS;
               next_data = {6'h00, frame[{next_cyc, 1'b1}], frame[{next_cyc, 1'b0}]};
            end
         end
         PLT_RX_ON: begin
            next_ctl = `PLT_CTL_RECEIVE;
            next_data = `PLT_DATA_ON;
            if (rx_end) begin
               next_state = PLT_IDLE;
               next_ctl = `PLT_CTL_IDLE;
               next_data = 8'h00;
            end else if (rx_valid) begin
               next_state = PLT_RX_SPEED;
               next_data = speed_code;
            end
         end
         PLT_RX_SPEED, PLT_RX_DATA: begin
            // The symbol on rx_symbol in this cycle, not a stored copy of the one that triggered the speed code, is delivered next
            next_state = PLT_RX_DATA;
            next_ctl = `PLT_CTL_RECEIVE;
            next_data = lanes;
            if (rx_end) begin
               next_state = PLT_IDLE;
               next_ctl = `PLT_CTL_IDLE;
               next_data = 8'h00;
            end
         end
         PLT_GRANT_IDLE: begin
            next_state = PLT_RELEASED;
         end
         PLT_RELEASED: begin
            // Link owns the lines until it releases
            next_drive_enable = 1'b0;
            if (link_release) begin
               next_state = PLT_IDLE;
               next_drive_enable = 1'b1;
            end
         end
         default: begin
            next_state = PLT_IDLE;
         end
      endcase
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         state <= PLT_IDLE;
         cyc <= 3'h0;
         long_xfer <= 1'b0;
         frame <= 16'h0000;
         idle_seen <= 1'b0;
         speed <= `PLT_SPEED_S100;
         interface_control_lines <= `PLT_CTL_IDLE;
         data_lines <= 8'h00;
         drive_enable <= 1'b1;
         request_clear <= 1'b0;
      end else begin
         state <= next_state;
         cyc <= next_cyc;
         long_xfer <= next_long_xfer;
         frame <= next_frame;
         idle_seen <= next_idle_seen;
         speed <= next_speed;
         interface_control_lines <= next_ctl;
         data_lines <= next_data;
         drive_enable <= next_drive_enable;
         request_clear <= next_request_clear;
      end
   end
endmodule // plt_link_if

/* File: logic/plt_rx_packer.sv */
// Maps a received symbol onto the data lines for the packet speed
`timescale 1ns/1ns
`include "plt_consts.svh"
module plt_rx_packer
   import plt_pkg::*;
(
   input wire logic [1:0] speed,
   input wire logic [7:0] symbol,
   output logic [7:0] lanes,
   output logic [7:0] speed_code
);
   always_comb begin
      lanes = 8'h00;
      speed_code = `PLT_SPD_S100;
      case (speed)
         `PLT_SPEED_S200: begin
            lanes = {4'h0, symbol[3:0]};
            speed_code = `PLT_SPD_S200;
         end
         `PLT_SPEED_S400: begin
            lanes = symbol;
            speed_code = `PLT_SPD_S400;
         end
         default: begin
            lanes = {6'h00, symbol[1:0]};
            speed_code = `PLT_SPD_S100;
         end
      endcase
   end
endmodule // plt_rx_packer

/* File: logic/plt_status_queue.sv */
// Pending status flags and register contents awaiting transfer
`timescale 1ns/1ns
`include "plt_consts.svh"
module plt_status_queue
   import plt_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [3:0] flag_set,
   input wire logic reg_load,
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_data,
   input wire logic flags_sent,
   input wire logic reg_sent,
   output logic [3:0] flags_pend,
   output logic reg_pend,
   output logic [11:0] reg_word
);
   logic [3:0] next_flags_pend;
   logic next_reg_pend;
   logic [11:0] next_reg_word;
   // ==========================================
   // Pending state
   always_comb begin
      // Set wins over clear so no flag event is lost
      next_flags_pend = (flags_sent ? 4'h0 : flags_pend) | flag_set;
      next_reg_pend = reg_pend;
      next_reg_word = reg_word;
      if (reg_sent) begin
         next_reg_pend = 1'b0;
      end
      if (reg_load && !(reg_pend && !reg_sent)) begin
         next_reg_pend = 1'b1;
         next_reg_word = {reg_data, reg_addr};
      end
   end
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         flags_pend <= 4'h0;
         reg_pend <= 1'b0;
         reg_word <= 12'h000;
      end else begin
         flags_pend <= next_flags_pend;
         reg_pend <= next_reg_pend;
         reg_word <= next_reg_word;
      end
   end
endmodule // plt_status_queue
